// [hdl/dusp_pkg.sv]
// constants shared by both ends of the dma user stream and read ports
package dusp_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DUSP_DATA_W = 64;
  localparam int DUSP_NUM_CH = 4;
  localparam int DUSP_MAX_CH = 4;
  localparam int DUSP_ADDR_W = 64;
  localparam int DUSP_ID_W = 4;
  localparam int DUSP_LEN_W = 8;
  localparam int DUSP_SIZE_W = 3;
  localparam bit DUSP_PARITY_EN = 1'b0;
  localparam int DUSP_BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // fixed read address attributes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DUSP_BURST_INCR = 2'h1;
  localparam logic [2:0] DUSP_PROT_VAL = 3'h0;
  localparam logic DUSP_LOCK_VAL = 1'h0;
  localparam logic [3:0] DUSP_CACHE_VAL = 4'h0;
  localparam logic [1:0] DUSP_RST_SYNC_INIT = 2'h0;
endpackage

// [hdl/dusp_if.sv]
// interface joining the dma end and the user end
`timescale 1ns/10ps
interface dusp_if #(
  parameter int DW = 64,
  parameter int NCH = 4,
  parameter int AW = 64,
  parameter int IDW = 4,
  parameter int PW = 1
);
  // reset from the dma end
  logic aresetn;
  // host to card streams
  logic [NCH-1:0] h2c_dma_valid;
  logic [NCH-1:0] h2c_user_ready;
  logic [NCH-1:0][DW-1:0] h2c_stream_data;
  logic [NCH-1:0][DW/8-1:0] h2c_byte_keep;
  logic [NCH-1:0] h2c_packet_last;
  logic [NCH-1:0][PW-1:0] h2c_parity_bits;
  // card to host streams
  logic [NCH-1:0] c2h_user_valid;
  logic [NCH-1:0] c2h_dma_ready;
  logic [NCH-1:0][DW-1:0] c2h_stream_data;
  logic [NCH-1:0][DW/8-1:0] c2h_byte_keep;
  logic [NCH-1:0] c2h_packet_last;
  logic [NCH-1:0][PW-1:0] c2h_parity_bits;
  // read address channel
  logic [AW-1:0] rd_addr;
  logic [IDW-1:0] rd_id;
  logic [7:0] rd_len;
  logic [2:0] rd_size;
  logic [1:0] rd_burst;
  logic [2:0] rd_prot;
  logic rd_lock;
  logic [3:0] rd_cache;
  logic rd_addr_valid;
  logic rd_addr_ready;

  modport dma (
    output aresetn,
    output h2c_dma_valid, h2c_stream_data, h2c_byte_keep, h2c_packet_last, h2c_parity_bits,
    input h2c_user_ready,
    input c2h_user_valid, c2h_stream_data, c2h_byte_keep, c2h_packet_last, c2h_parity_bits,
    output c2h_dma_ready,
    output rd_addr, rd_id, rd_len, rd_size, rd_burst, rd_prot, rd_lock, rd_cache,
    output rd_addr_valid,
    input rd_addr_ready
  );

  modport usr (
    input aresetn,
    input h2c_dma_valid, h2c_stream_data, h2c_byte_keep, h2c_packet_last, h2c_parity_bits,
    output h2c_user_ready,
    output c2h_user_valid, c2h_stream_data, c2h_byte_keep, c2h_packet_last, c2h_parity_bits,
    input c2h_dma_ready,
    input rd_addr, rd_id, rd_len, rd_size, rd_burst, rd_prot, rd_lock, rd_cache,
    input rd_addr_valid,
    output rd_addr_ready
  );
endinterface

// [hdl/dusp_dma_end.sv]
// dma end: two-entry buffer, stream channels, read address channel, reset out
// Notes on behaviour
// (RULE1) h2c beat moves when valid and ready
// (RULE2) user ready may drop any time
// (RULE3) stalled h2c beat held until ready
// (RULE4) h2c valid marks every meaningful data word
// (RULE5) h2c last only on final beat
// (RULE6) h2c keep shows valid bytes at end
// (RULE7) parity bits only with parity option
// (RULE8) c2h beat moves when valid and ready
// (RULE9) user holds c2h beat while stalled
// (RULE10) user valid marks meaningful c2h words
// (RULE11) user flags last c2h beat
// (RULE12) c2h keep all ones except final
// (RULE13) four independent channels per direction
// (RULE14) read address of configurable width
// (RULE15) read valid only with real request
// (RULE16) eight-bit burst length field
// (RULE17) three-bit burst size field
// (RULE18) prot, lock, cache held at zero
// (RULE19) all ports on the one clock
// (RULE20) active-low reset released synchronously, drives user
`timescale 1ns/10ps
module dusp_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  import dusp_pkg::*;

  logic [W-1:0] mem [DUSP_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // head entry stays put until popped
  assign out_data_o = mem[rd_ptr];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop)
      begin
        count <= count + 2'h1;
      end
      else if (pop && !push)
      begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

module dusp_dma_end #(
  parameter int DW = dusp_pkg::DUSP_DATA_W,
  parameter int NCH = dusp_pkg::DUSP_NUM_CH,
  parameter int AW = dusp_pkg::DUSP_ADDR_W,
  parameter int IDW = dusp_pkg::DUSP_ID_W,
  parameter bit PAR = dusp_pkg::DUSP_PARITY_EN,
  parameter int PW = PAR ? DW / 8 : 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // host to card words from the engine
  input wire logic [NCH-1:0] h2c_core_valid_i,
  output logic [NCH-1:0] h2c_core_ready_o,
  input wire logic [NCH-1:0][DW-1:0] h2c_core_data_i,
  input wire logic [NCH-1:0][DW/8-1:0] h2c_core_keep_i,
  input wire logic [NCH-1:0] h2c_core_last_i,
  input wire logic [NCH-1:0][PW-1:0] h2c_core_parity_i,
  // card to host words to the engine
  output logic [NCH-1:0] c2h_core_valid_o,
  input wire logic [NCH-1:0] c2h_core_ready_i,
  output logic [NCH-1:0][DW-1:0] c2h_core_data_o,
  output logic [NCH-1:0][DW/8-1:0] c2h_core_keep_o,
  output logic [NCH-1:0] c2h_core_last_o,
  output logic [NCH-1:0][PW-1:0] c2h_core_parity_o,
  // read requests from the engine
  input wire logic rd_req_valid_i,
  output logic rd_req_ready_o,
  input wire logic [AW-1:0] rd_req_addr_i,
  input wire logic [IDW-1:0] rd_req_id_i,
  input wire logic [dusp_pkg::DUSP_LEN_W-1:0] rd_req_len_i,
  input wire logic [dusp_pkg::DUSP_SIZE_W-1:0] rd_req_size_i,
  // user side link
  dusp_if.dma bus
);
  import dusp_pkg::*;

  localparam int KW = DW / 8;
  localparam int SW = DW + KW + 1 + PW;
  localparam int RW = AW + IDW + DUSP_LEN_W + DUSP_SIZE_W;

  logic [1:0] rst_sync;
  logic [RW-1:0] rd_word;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DW < 8 || DW % 8 != 0)
  begin : g_chk_dw
    $error("data width must be a nonzero multiple of eight");
  end
  if (NCH < 1 || NCH > DUSP_MAX_CH)
  begin : g_chk_nch
    $error("channel count must be one to four");
  end
  if (AW < 1 || IDW < 1)
  begin : g_chk_aw
    $error("address and id widths must be nonzero");
  end
  if (PW != (PAR ? DW / 8 : 1))
  begin : g_chk_pw
    $error("parity width must match the parity option");
  end

  // ----------------------------------------------------------------
  // user reset, asserted at once, released on the clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_sync <= DUSP_RST_SYNC_INIT;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1}; // [RULE20]
    end
  end
  assign bus.aresetn = rst_sync[1]; // [RULE19] [RULE20]

  // ----------------------------------------------------------------
  // stream channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch // [RULE13]
    logic [SW-1:0] h2c_in;
    logic [SW-1:0] h2c_out;
    logic [SW-1:0] c2h_in;
    logic [SW-1:0] c2h_out;
    logic [KW-1:0] h2c_keep;
    logic [PW-1:0] h2c_par;
    logic [PW-1:0] c2h_par;

    // keep is all ones inside a packet, real count on the last beat
    assign h2c_keep = h2c_core_last_i[g] ? h2c_core_keep_i[g] : {KW{1'b1}}; // [RULE6]
    assign h2c_par = PAR ? h2c_core_parity_i[g] : '0; // [RULE7]
    assign h2c_in = {h2c_par, h2c_core_last_i[g], h2c_keep, h2c_core_data_i[g]};

    // head beat holds until the user takes it
    dusp_buf2 #(.W(SW)) u_h2c_buf (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(h2c_core_valid_i[g]),
      .in_ready_o(h2c_core_ready_o[g]),
      .in_data_i(h2c_in),
      .out_valid_o(bus.h2c_dma_valid[g]), // [RULE3] [RULE4]
      .out_ready_i(bus.h2c_user_ready[g]), // [RULE1] [RULE2]
      .out_data_o(h2c_out)
    );
    assign bus.h2c_stream_data[g] = h2c_out[DW-1:0];
    assign bus.h2c_byte_keep[g] = h2c_out[DW+KW-1:DW];
    assign bus.h2c_packet_last[g] = h2c_out[DW+KW]; // [RULE5]
    assign bus.h2c_parity_bits[g] = h2c_out[SW-1:DW+KW+1];

    assign c2h_par = PAR ? bus.c2h_parity_bits[g] : '0; // [RULE7]
    assign c2h_in = {c2h_par, bus.c2h_packet_last[g], bus.c2h_byte_keep[g],
                     bus.c2h_stream_data[g]};

    // ready drops only when both entries hold beats
    dusp_buf2 #(.W(SW)) u_c2h_buf (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(bus.c2h_user_valid[g]), // [RULE10]
      .in_ready_o(bus.c2h_dma_ready[g]), // [RULE8] [RULE9]
      .in_data_i(c2h_in),
      .out_valid_o(c2h_core_valid_o[g]),
      .out_ready_i(c2h_core_ready_i[g]),
      .out_data_o(c2h_out)
    );
    assign c2h_core_data_o[g] = c2h_out[DW-1:0];
    assign c2h_core_keep_o[g] = c2h_out[DW+KW-1:DW]; // [RULE12]
    assign c2h_core_last_o[g] = c2h_out[DW+KW]; // [RULE11]
    assign c2h_core_parity_o[g] = c2h_out[SW-1:DW+KW+1];
  end

  // ----------------------------------------------------------------
  // read address channel
  // ----------------------------------------------------------------
  dusp_buf2 #(.W(RW)) u_rd_buf (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(rd_req_valid_i),
    .in_ready_o(rd_req_ready_o),
    .in_data_i({rd_req_addr_i, rd_req_id_i, rd_req_len_i, rd_req_size_i}),
    .out_valid_o(bus.rd_addr_valid), // [RULE15]
    .out_ready_i(bus.rd_addr_ready),
    .out_data_o(rd_word)
  );
  assign bus.rd_addr = rd_word[RW-1:IDW+DUSP_LEN_W+DUSP_SIZE_W]; // [RULE14]
  assign bus.rd_id = rd_word[IDW+DUSP_LEN_W+DUSP_SIZE_W-1:DUSP_LEN_W+DUSP_SIZE_W];
  assign bus.rd_len = rd_word[DUSP_LEN_W+DUSP_SIZE_W-1:DUSP_SIZE_W]; // [RULE16]
  assign bus.rd_size = rd_word[DUSP_SIZE_W-1:0]; // [RULE17]
  assign bus.rd_burst = DUSP_BURST_INCR;
  assign bus.rd_prot = DUSP_PROT_VAL; // [RULE18]
  assign bus.rd_lock = DUSP_LOCK_VAL; // [RULE18]
  assign bus.rd_cache = DUSP_CACHE_VAL; // [RULE18]
endmodule

// [hdl/dusp_user_end.sv]
// user end: stream sinks and sources and read address slave
`timescale 1ns/10ps
module dusp_user_end #(
  parameter int DW = dusp_pkg::DUSP_DATA_W,
  parameter int NCH = dusp_pkg::DUSP_NUM_CH,
  parameter int AW = dusp_pkg::DUSP_ADDR_W,
  parameter int IDW = dusp_pkg::DUSP_ID_W,
  parameter bit PAR = dusp_pkg::DUSP_PARITY_EN,
  parameter int PW = PAR ? DW / 8 : 1
) (
  // clock
  input wire logic clk_sys_i,
  // host to card words to user logic
  output logic [NCH-1:0] sink_valid_o,
  input wire logic [NCH-1:0] sink_ready_i,
  output logic [NCH-1:0][DW-1:0] sink_data_o,
  output logic [NCH-1:0][DW/8-1:0] sink_keep_o,
  output logic [NCH-1:0] sink_last_o,
  output logic [NCH-1:0][PW-1:0] sink_parity_o,
  // card to host words from user logic
  input wire logic [NCH-1:0] src_valid_i,
  output logic [NCH-1:0] src_ready_o,
  input wire logic [NCH-1:0][DW-1:0] src_data_i,
  input wire logic [NCH-1:0][DW/8-1:0] src_keep_i,
  input wire logic [NCH-1:0] src_last_i,
  input wire logic [NCH-1:0][PW-1:0] src_parity_i,
  // read requests to user memory
  output logic mem_rd_valid_o,
  input wire logic mem_rd_ready_i,
  output logic [AW-1:0] mem_rd_addr_o,
  output logic [IDW-1:0] mem_rd_id_o,
  output logic [dusp_pkg::DUSP_LEN_W-1:0] mem_rd_len_o,
  output logic [dusp_pkg::DUSP_SIZE_W-1:0] mem_rd_size_o,
  // reset seen by user logic
  output logic user_rst_o,
  // dma side link
  dusp_if.usr bus
);
  import dusp_pkg::*;

  localparam int KW = DW / 8;
  localparam int SW = DW + KW + 1 + PW;
  localparam int RW = AW + IDW + DUSP_LEN_W + DUSP_SIZE_W;

  logic user_rst;
  logic rd_rdy;
  logic [RW-1:0] rd_word;

  if (DW < 8 || DW % 8 != 0 || NCH < 1 || NCH > DUSP_MAX_CH || PW != (PAR ? DW / 8 : 1))
  begin : g_chk
    $error("unsupported data width or channel count");
  end

  // ----------------------------------------------------------------
  // user logic resets from the dma reset output
  // ----------------------------------------------------------------
  assign user_rst = ~bus.aresetn; // [RULE20]
  assign user_rst_o = user_rst;

  // ----------------------------------------------------------------
  // stream channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch // [RULE13]
    logic [SW-1:0] h2c_out;
    logic [SW-1:0] c2h_in;
    logic [SW-1:0] c2h_out;
    logic [KW-1:0] src_keep;
    logic [PW-1:0] src_par;
    logic h2c_rdy;

    // no beat is taken while the user side is held in reset
    assign bus.h2c_user_ready[g] = h2c_rdy && bus.aresetn; // [RULE1] [RULE2]

    dusp_buf2 #(.W(SW)) u_h2c_buf (
      .clk_sys_i(clk_sys_i),
      .rst_i(user_rst),
      .in_valid_i(bus.h2c_dma_valid[g]),
      .in_ready_o(h2c_rdy),
      .in_data_i({bus.h2c_parity_bits[g], bus.h2c_packet_last[g], bus.h2c_byte_keep[g],
                  bus.h2c_stream_data[g]}),
      .out_valid_o(sink_valid_o[g]),
      .out_ready_i(sink_ready_i[g]),
      .out_data_o(h2c_out)
    );
    assign sink_data_o[g] = h2c_out[DW-1:0];
    assign sink_keep_o[g] = h2c_out[DW+KW-1:DW];
    assign sink_last_o[g] = h2c_out[DW+KW];
    assign sink_parity_o[g] = PAR ? h2c_out[SW-1:DW+KW+1] : '0; // [RULE7]

    assign src_keep = src_last_i[g] ? src_keep_i[g] : {KW{1'b1}}; // [RULE12]
    assign src_par = PAR ? src_parity_i[g] : '0; // [RULE7]
    assign c2h_in = {src_par, src_last_i[g], src_keep, src_data_i[g]};

    // head beat holds while the dma stalls
    dusp_buf2 #(.W(SW)) u_c2h_buf (
      .clk_sys_i(clk_sys_i),
      .rst_i(user_rst),
      .in_valid_i(src_valid_i[g]),
      .in_ready_o(src_ready_o[g]),
      .in_data_i(c2h_in),
      .out_valid_o(bus.c2h_user_valid[g]), // [RULE9] [RULE10]
      .out_ready_i(bus.c2h_dma_ready[g]), // [RULE8]
      .out_data_o(c2h_out)
    );
    assign bus.c2h_stream_data[g] = c2h_out[DW-1:0];
    assign bus.c2h_byte_keep[g] = c2h_out[DW+KW-1:DW];
    assign bus.c2h_packet_last[g] = c2h_out[DW+KW]; // [RULE11]
    assign bus.c2h_parity_bits[g] = c2h_out[SW-1:DW+KW+1];
  end

  // ----------------------------------------------------------------
  // read address slave
  // ----------------------------------------------------------------
  dusp_buf2 #(.W(RW)) u_rd_buf (
    .clk_sys_i(clk_sys_i),
    .rst_i(user_rst),
    .in_valid_i(bus.rd_addr_valid),
    .in_ready_o(rd_rdy),
    .in_data_i({bus.rd_addr, bus.rd_id, bus.rd_len, bus.rd_size}),
    .out_valid_o(mem_rd_valid_o),
    .out_ready_i(mem_rd_ready_i),
    .out_data_o(rd_word)
  );
  // no request is taken while the user side is held in reset
  assign bus.rd_addr_ready = rd_rdy && bus.aresetn;
  assign mem_rd_addr_o = rd_word[RW-1:IDW+DUSP_LEN_W+DUSP_SIZE_W];
  assign mem_rd_id_o = rd_word[IDW+DUSP_LEN_W+DUSP_SIZE_W-1:DUSP_LEN_W+DUSP_SIZE_W];
  assign mem_rd_len_o = rd_word[DUSP_LEN_W+DUSP_SIZE_W-1:DUSP_SIZE_W];
  assign mem_rd_size_o = rd_word[DUSP_SIZE_W-1:0];
endmodule

// [sim/dusp_checker.sv]
// concurrent checks on the link between the two ends
`timescale 1ns/10ps
module dusp_checker #(
  parameter int DW = 64,
  parameter int NCH = 4,
  parameter int AW = 64
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic aresetn,
  // streams
  input wire logic [NCH-1:0] h2c_dma_valid,
  input wire logic [NCH-1:0] h2c_user_ready,
  input wire logic [NCH-1:0][DW-1:0] h2c_stream_data,
  input wire logic [NCH-1:0][DW/8-1:0] h2c_byte_keep,
  input wire logic [NCH-1:0] h2c_packet_last,
  input wire logic [NCH-1:0] c2h_user_valid,
  input wire logic [NCH-1:0] c2h_dma_ready,
  input wire logic [NCH-1:0][DW-1:0] c2h_stream_data,
  input wire logic [NCH-1:0][DW/8-1:0] c2h_byte_keep,
  input wire logic [NCH-1:0] c2h_packet_last,
  // read address
  input wire logic [AW-1:0] rd_addr,
  input wire logic [7:0] rd_len,
  input wire logic [2:0] rd_size,
  input wire logic [1:0] rd_burst,
  input wire logic [2:0] rd_prot,
  input wire logic rd_lock,
  input wire logic [3:0] rd_cache,
  input wire logic rd_addr_valid,
  input wire logic rd_addr_ready
);
  import dusp_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!aresetn);
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    a_h2c_valid_hold: assert property (
      h2c_dma_valid[g] && !h2c_user_ready[g] |=> h2c_dma_valid[g])
      else $error("h2c valid dropped while stalled");
    a_h2c_beat_stable: assert property (
      h2c_dma_valid[g] && !h2c_user_ready[g] |=>
      $stable({h2c_stream_data[g], h2c_byte_keep[g], h2c_packet_last[g]}))
      else $error("h2c beat changed while stalled");
    a_h2c_keep_full: assert property (
      h2c_dma_valid[g] && !h2c_packet_last[g] |-> &h2c_byte_keep[g])
      else $error("h2c keep not full on inner beat");
    a_c2h_keep_full: assert property (
      c2h_user_valid[g] && !c2h_packet_last[g] |-> &c2h_byte_keep[g])
      else $error("c2h keep not full on inner beat");
    a_c2h_beat_hold: assert property (
      c2h_user_valid[g] && !c2h_dma_ready[g] |=> c2h_user_valid[g] &&
      $stable({c2h_stream_data[g], c2h_byte_keep[g], c2h_packet_last[g]}))
      else $error("c2h beat not held while stalled");
  end
  a_rd_fixed_attr: assert property (
    rd_addr_valid |-> {rd_prot, rd_lock, rd_cache, rd_burst} == 10'h001)
    else $error("read attributes not fixed");
  a_rd_req_hold: assert property (
    rd_addr_valid && !rd_addr_ready |=>
    rd_addr_valid && $stable({rd_addr, rd_len, rd_size}))
    else $error("read request not held");
  a_idle_in_reset: assert property (disable iff (1'b0)
    !aresetn |-> !(|h2c_dma_valid) && !(|c2h_user_valid) && !rd_addr_valid &&
    !(|h2c_user_ready) && !rd_addr_ready)
    else $error("handshake seen during reset");
  cover property (h2c_dma_valid[0] && !h2c_user_ready[0]);
  cover property (c2h_user_valid[0] && !c2h_dma_ready[0]);
  cover property (rd_addr_valid && !rd_addr_ready);
  cover property (h2c_dma_valid[0] && h2c_user_ready[0] && h2c_packet_last[0]);
endmodule

// [sim/tb_top.sv]
// self-checking bench for both ends of the dma user link
`timescale 1ns/10ps
module tb_top;
  import dusp_pkg::*;
  localparam int NCH = DUSP_NUM_CH;
  localparam int DW = DUSP_DATA_W;
  localparam int WW = DW + DW / 8 + 2;
  localparam int RW = DUSP_ADDR_W + DUSP_ID_W + DUSP_LEN_W + DUSP_SIZE_W;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic stall = 1'b0;
  integer seed = 73714;
  integer fails = 0;
  integer samples_checked = 0;
  integer pending = 0;
  integer cycles = 0;
  logic [NCH-1:0] h_v, h_r, h_l, s_v, s_r, s_l, u_v, u_r, u_l, c_v, c_r, c_l;
  logic [NCH-1:0][DW-1:0] h_d, s_d, u_d, c_d;
  logic [NCH-1:0][DW/8-1:0] h_k, s_k, u_k, c_k;
  logic [NCH-1:0][0:0] h_p, s_p, u_p, c_p;
  logic q_v, q_r, m_v, m_r;
  logic u_rst;
  logic [DUSP_ADDR_W-1:0] q_a, m_a;
  logic [DUSP_ID_W-1:0] q_i, m_i;
  logic [7:0] q_n, m_n;
  logic [2:0] q_z, m_z;
  logic [RW-1:0] rq[$];
  // ----------------------------------------------------------------
  // design and checker
  // ----------------------------------------------------------------
  dusp_if #(.DW(DW), .NCH(NCH), .AW(DUSP_ADDR_W), .IDW(DUSP_ID_W), .PW(1)) bus ();
  dusp_dma_end i_dusp_dma_end (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .h2c_core_valid_i(h_v), .h2c_core_ready_o(h_r), .h2c_core_data_i(h_d),
    .h2c_core_keep_i(h_k), .h2c_core_last_i(h_l), .h2c_core_parity_i(h_p),
    .c2h_core_valid_o(c_v), .c2h_core_ready_i(c_r), .c2h_core_data_o(c_d),
    .c2h_core_keep_o(c_k), .c2h_core_last_o(c_l), .c2h_core_parity_o(c_p),
    .rd_req_valid_i(q_v), .rd_req_ready_o(q_r), .rd_req_addr_i(q_a), .rd_req_id_i(q_i),
    .rd_req_len_i(q_n), .rd_req_size_i(q_z), .bus(bus));
  dusp_user_end i_dusp_user_end (.clk_sys_i(clk_sys_i),
    .sink_valid_o(s_v), .sink_ready_i(s_r), .sink_data_o(s_d), .sink_keep_o(s_k),
    .sink_last_o(s_l), .sink_parity_o(s_p), .src_valid_i(u_v), .src_ready_o(u_r),
    .src_data_i(u_d), .src_keep_i(u_k), .src_last_i(u_l), .src_parity_i(u_p),
    .mem_rd_valid_o(m_v), .mem_rd_ready_i(m_r), .mem_rd_addr_o(m_a), .mem_rd_id_o(m_i),
    .mem_rd_len_o(m_n), .mem_rd_size_o(m_z), .user_rst_o(u_rst), .bus(bus));
  dusp_checker #(.DW(DW), .NCH(NCH), .AW(DUSP_ADDR_W)) i_dusp_checker (
    .clk_sys_i(clk_sys_i), .aresetn(bus.aresetn), .h2c_dma_valid(bus.h2c_dma_valid),
    .h2c_user_ready(bus.h2c_user_ready), .h2c_stream_data(bus.h2c_stream_data),
    .h2c_byte_keep(bus.h2c_byte_keep), .h2c_packet_last(bus.h2c_packet_last),
    .c2h_user_valid(bus.c2h_user_valid), .c2h_dma_ready(bus.c2h_dma_ready),
    .c2h_stream_data(bus.c2h_stream_data), .c2h_byte_keep(bus.c2h_byte_keep),
    .c2h_packet_last(bus.c2h_packet_last), .rd_addr(bus.rd_addr), .rd_len(bus.rd_len),
    .rd_size(bus.rd_size), .rd_burst(bus.rd_burst), .rd_prot(bus.rd_prot),
    .rd_lock(bus.rd_lock), .rd_cache(bus.rd_cache), .rd_addr_valid(bus.rd_addr_valid),
    .rd_addr_ready(bus.rd_addr_ready));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #20 clk_sys_i = ~clk_sys_i;
  function automatic logic [WW-1:0] exp_word(input logic [DW-1:0] d, input logic [7:0] k,
    input logic l);
    return {d, l ? k : 8'hFF, l, 1'b0};
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t ns: got %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic reset_pulse();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    pending = 0;
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 check(bus.aresetn, 1'b0);
    check({u_rst, bus.h2c_user_ready, bus.rd_addr_ready}, 6'h20);
    @(posedge clk_sys_i);
    #1 check(bus.aresetn, 1'b1);
    check({u_rst, bus.h2c_user_ready, bus.rd_addr_ready}, 6'h1F);
    @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // per channel sources and monitors
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    logic [WW-1:0] hq[$];
    logic [WW-1:0] cq[$];
    always @(posedge clk_sys_i)
    begin
      logic lst;
      if (rst_i)
      begin
        hq.delete();
        cq.delete();
      end
      if (h_v[g] && h_r[g] && !rst_i)
      begin
        hq.push_back(exp_word(h_d[g], h_k[g], h_l[g]));
        pending++;
      end
      if (u_v[g] && u_r[g] && !rst_i)
      begin
        cq.push_back(exp_word(u_d[g], u_k[g], u_l[g]));
        pending++;
      end
      if (!go)
        h_v[g] <= 1'b0;
      else if (!h_v[g] || h_r[g])
      begin
        h_v[g] <= stall || ($random(seed) & 3) != 0;
        h_d[g] <= {$random(seed), $random(seed)};
        h_k[g] <= 8'($random(seed));
        h_l[g] <= ($random(seed) & 3) == 0;
      end
      lst = ($random(seed) & 3) == 0;
      if (!go)
        u_v[g] <= 1'b0;
      else if (!u_v[g] || u_r[g])
      begin
        u_v[g] <= stall || ($random(seed) & 3) != 0;
        u_d[g] <= {$random(seed), $random(seed)};
        u_k[g] <= lst ? 8'($random(seed)) : 8'hFF;
        u_l[g] <= lst;
      end
      s_r[g] <= !stall && ($random(seed) & 3) != 0;
      c_r[g] <= !stall && ($random(seed) & 3) != 0;
      if (s_v[g] && s_r[g] && !rst_i)
      begin
        check({s_d[g], s_k[g], s_l[g], s_p[g]},
              hq.size() ? hq.pop_front() : 'x);
        pending--;
      end
      if (c_v[g] && c_r[g] && !rst_i)
      begin
        check({c_d[g], c_k[g], c_l[g], c_p[g]},
              cq.size() ? cq.pop_front() : 'x);
        pending--;
      end
      if (bus.h2c_dma_valid[g] && !bus.h2c_packet_last[g] && !rst_i)
        check(bus.h2c_byte_keep[g], 8'hFF);
    end
  end
  // ----------------------------------------------------------------
  // read requests and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      rq.delete();
    if (q_v && q_r && !rst_i)
    begin
      rq.push_back({q_a, q_i, q_n, q_z});
      pending++;
    end
    if (!go)
      q_v <= 1'b0;
    else if (!q_v || q_r)
    begin
      q_v <= stall || ($random(seed) & 3) != 0;
      q_a <= {$random(seed), $random(seed)};
      q_i <= 4'($random(seed));
      q_n <= 8'($random(seed));
      q_z <= 3'($random(seed) & 3);
    end
    m_r <= !stall && ($random(seed) & 3) != 0;
    if (m_v && m_r && !rst_i)
    begin
      check({m_a, m_i, m_n, m_z}, rq.size() ? rq.pop_front() : 'x);
      pending--;
    end
    if (bus.rd_addr_valid && !rst_i)
      check({bus.rd_prot, bus.rd_lock, bus.rd_cache, bus.rd_burst}, 10'h001);
  end
  initial
  begin
    {h_v, h_l, h_d, h_k, h_p, u_v, u_l, u_d, u_k, u_p} = '0;
    {s_r, c_r, q_v, q_a, q_i, q_n, q_z, m_r} = '0;
    reset_pulse();
    go <= 1'b1;
    repeat (300) @(posedge clk_sys_i);
    stall <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1 check({h_r, u_r, q_r}, '0);
    @(posedge clk_sys_i);
    stall <= 1'b0;
    repeat (300) @(posedge clk_sys_i);
    go <= 1'b0;
    reset_pulse();
    go <= 1'b1;
    repeat (300) @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 200 && pending != 0; i++)
      @(posedge clk_sys_i);
    check(pending, 0);
    test_done();
  end
endmodule
